// >>> mdiot_pins_model.sv
// far side: external digital lines and a ttl pulse source
// assumes the bench clock and the pins of mdiot_top
`default_nettype none
module mdiot_pins_model
    import mdiot_pkg::*;
(
    input wire logic i_clock,
    input wire logic [7:0] i_out1,
    input wire logic [7:0] i_oe1,
    input wire logic [7:0] i_out2,
    input wire logic [7:0] i_oe2,
    output logic [7:0] o_pins1,
    output logic [7:0] o_pins2,
    output var logic o_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ext1 = 8'h00;
    logic [7:0] ext2 = 8'h00;
    initial o_pulse = 1'b0;
    // sources let go of a line the block drives, so the wire follows the block
    assign o_pins1 = (i_oe1 & i_out1) | (~i_oe1 & ext1);
    assign o_pins2 = (i_oe2 & i_out2) | (~i_oe2 & ext2);
    task automatic set_pins(input logic [7:0] a, input logic [7:0] b);
        ext1 <= a;
        ext2 <= b;
    endtask : set_pins
    // never faster than the rated rate: one level per PULSE_MIN_CYC clocks
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (PULSE_MIN_CYC) @(posedge i_clock);
            o_pulse <= ~o_pulse;
        end
    endtask : toggle
endmodule : mdiot_pins_model
`default_nettype wire

// >>> mdiot_pkg.sv
// package for the multifunction digital io / totalizer block
// assumes a single 10 MHz clock and an axi4-lite register bus
`default_nettype none
package mdiot_pkg;
    // --------------------------------------------------------------
    // register byte addresses
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT1_IN = 8'h00;
    localparam logic [7:0] ADDR_PORT1_OUT = 8'h04;
    localparam logic [7:0] ADDR_PORT1_CFG = 8'h08;
    localparam logic [7:0] ADDR_PORT2_IN = 8'h10;
    localparam logic [7:0] ADDR_PORT2_OUT = 8'h14;
    localparam logic [7:0] ADDR_PORT2_CFG = 8'h18;
    localparam logic [7:0] ADDR_TOT_COUNT = 8'h20;
    localparam logic [7:0] ADDR_TOT_CFG = 8'h24;
    localparam logic [7:0] ADDR_TOT_CLEAR = 8'h28;
    localparam logic [7:0] ADDR_CHAN_ID = 8'h2c;
    // --------------------------------------------------------------
    // fields and constants
    // --------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int COUNT_W = 26;
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_BASE_BIT = 1;
    localparam int TOT_MODE_BIT = 0;
    localparam int TOT_EDGE_BIT = 1;
    localparam logic [7:0] CHAN_PORT1 = 8'h01;
    localparam logic [7:0] CHAN_PORT2 = 8'h02;
    localparam logic [7:0] CHAN_TOT = 8'h03;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 26'h000_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 26'h000_0001;
    // 100 kHz pulses give >= 5 us per level at 10 MHz, ample for sampling
    localparam int CLK_HZ = 10_000_000;
    localparam int PULSE_MAX_HZ = 100_000;
    localparam int PULSE_MIN_CYC = CLK_HZ / (2 * PULSE_MAX_HZ);
endpackage : mdiot_pkg
`default_nettype wire

// >>> mdiot_port.sv
// one 8-bit digital port: direction and output latch
// assumes writes come from the register slave of the top
`default_nettype none
module mdiot_port
    import mdiot_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    mdiot_port_if.port bus
);
    typedef struct packed {
        logic dir_out;
        logic [PORT_W-1:0] pattern;
    } mdiot_pstate_type;
    mdiot_pstate_type st_ff;
    mdiot_pstate_type nxt_st;
    always_comb begin
        nxt_st = st_ff;
        if (bus.wr_dir) begin
            nxt_st.dir_out = bus.wdata[CFG_DIR_BIT];
        end
        if (bus.wr_pat) begin
            nxt_st.dir_out = 1'b1;
            nxt_st.pattern = bus.wdata;
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign bus.dir_out = st_ff.dir_out;
    assign bus.pattern = st_ff.pattern;
endmodule : mdiot_port
`default_nettype wire

// >>> mdiot_port_if.sv
// interface between the top and the digital port module
// assumes both ends share i_clock
`default_nettype none
interface mdiot_port_if;
    logic wr_dir;
    logic wr_pat;
    logic [7:0] wdata;
    logic dir_out;
    logic [7:0] pattern;
    modport ctrl (output wr_dir, output wr_pat, output wdata, input dir_out, input pattern);
    modport port (input wr_dir, input wr_pat, input wdata, output dir_out, output pattern);
endinterface : mdiot_port_if
`default_nettype wire

// >>> mdiot_top.sv
// multifunction digital io ports and pulse totalizer, axi4-lite slave
// assumes pins and the pulse input are synchronous to i_clock
`default_nettype none
// Notes on behaviour
// - two independent 8-bit ports, each input or output under host control.
// - a port read returns the live pin levels and may serve as a scan entry.
// - preparing an output pattern switches the port to output direction.
// - a written pattern stays latched on the pins until rewritten.
// - a binary/decimal base is kept per port and stays until changed.
// - ports are channels 01 and 02, the totalizer channel 03.
// - a 26-bit counter counts ttl pulses up to 100 kHz.
// - counting starts at power-up with no start command.
// - mode selects clear-on-read or run until a manual clear.
// - the count is sampled once per read, never refreshed on its own.
// - counting edge is rising or falling, as configured.
module mdiot_top
    import mdiot_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [7:0] i_port1_pins,
    input wire logic [7:0] i_port2_pins,
    output logic [7:0] o_port1_pins,
    output logic [7:0] o_port1_oe,
    output logic [7:0] o_port2_pins,
    output logic [7:0] o_port2_oe,
    input wire logic i_pulse,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic w_low;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_ready;
        logic w_ready;
        logic ar_ready;
        logic base1;
        logic base2;
        logic tot_clr_on_read;
        logic tot_falling;
        logic pulse_prev;
        logic [COUNT_W-1:0] count;
        logic [7:0] p1_out;
        logic [7:0] p1_oe;
        logic [7:0] p2_out;
        logic [7:0] p2_oe;
    } mdiot_state_type;
    mdiot_state_type st_ff;
    mdiot_state_type nxt_st;

    // readies idle high so a master never meets a stalled bus out of reset
    localparam mdiot_state_type ST_RESET = '{
        aw_ready: 1'b1,
        w_ready: 1'b1,
        ar_ready: 1'b1,
        default: '0
    };

    // the two ports are identical, one instance each
    mdiot_port_if port1_bus ();
    mdiot_port_if port2_bus ();

    mdiot_port u_port1 (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .bus(port1_bus.port)
    );
    mdiot_port u_port2 (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .bus(port2_bus.port)
    );

    logic do_write;
    logic do_read;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_low;
    logic edge_seen;
    logic pulse_rise;
    logic pulse_fall;
    logic count_at_top;
    logic wr_p1_out;
    logic wr_p2_out;
    logic wr_p1_cfg;
    logic wr_p2_cfg;
    logic wr_tot_clr;
    logic rd_clear;
    logic [31:0] rd_value;
    logic rd_err;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    always_comb begin
        wr_addr = st_ff.aw_hold ? st_ff.aw_addr : i_s_axi_awaddr;
        wr_data = st_ff.w_hold ? st_ff.w_data : i_s_axi_wdata;
        // a write needs both halves and a free response slot
        do_write = (st_ff.aw_hold | i_s_axi_awvalid) & (st_ff.w_hold | i_s_axi_wvalid)
            & ~st_ff.bvalid;
        // a held word keeps the strobe it came with
        wr_low = st_ff.w_hold ? st_ff.w_low : i_s_axi_wstrb[0];
        do_read = i_s_axi_arvalid & st_ff.ar_ready;
    end

    // one strobe per port output and config register and one for the totalizer clear
    always_comb begin
        wr_p1_out = do_write & wr_low & (wr_addr == ADDR_PORT1_OUT);
        wr_p2_out = do_write & wr_low & (wr_addr == ADDR_PORT2_OUT);
        wr_p1_cfg = do_write & wr_low & (wr_addr == ADDR_PORT1_CFG);
        wr_p2_cfg = do_write & wr_low & (wr_addr == ADDR_PORT2_CFG);
        wr_tot_clr = do_write & wr_low & (wr_addr == ADDR_TOT_CLEAR);
    end

    always_comb begin
        port1_bus.wdata = wr_data[PORT_W-1:0];
        port2_bus.wdata = wr_data[PORT_W-1:0];
        port1_bus.wr_dir = wr_p1_cfg;
        port2_bus.wr_dir = wr_p2_cfg;
        port1_bus.wr_pat = wr_p1_out;
        port2_bus.wr_pat = wr_p2_out;
    end

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    // unaligned or unused addresses fall to the error branch
    always_comb begin
        rd_value = DATA_ZERO;
        rd_err = 1'b0;
        rd_clear = 1'b0;
        case (i_s_axi_araddr)
            ADDR_PORT1_IN: rd_value[PORT_W-1:0] = i_port1_pins;
            ADDR_PORT2_IN: rd_value[PORT_W-1:0] = i_port2_pins;
            ADDR_PORT1_OUT: rd_value[PORT_W-1:0] = port1_bus.pattern;
            ADDR_PORT2_OUT: rd_value[PORT_W-1:0] = port2_bus.pattern;
            ADDR_PORT1_CFG: begin
                rd_value[CFG_DIR_BIT] = port1_bus.dir_out;
                rd_value[CFG_BASE_BIT] = st_ff.base1;
            end
            ADDR_PORT2_CFG: begin
                rd_value[CFG_DIR_BIT] = port2_bus.dir_out;
                rd_value[CFG_BASE_BIT] = st_ff.base2;
            end
            ADDR_TOT_COUNT: begin
                rd_value[COUNT_W-1:0] = st_ff.count;
                rd_clear = st_ff.tot_clr_on_read;
            end
            ADDR_TOT_CFG: begin
                rd_value[TOT_MODE_BIT] = st_ff.tot_clr_on_read;
                rd_value[TOT_EDGE_BIT] = st_ff.tot_falling;
            end
            ADDR_TOT_CLEAR: rd_value = DATA_ZERO;
            ADDR_CHAN_ID: rd_value = {8'h00, CHAN_TOT, CHAN_PORT2, CHAN_PORT1};
            default: rd_err = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // ------------------------------------------------------------
        // axi write channels
        // ------------------------------------------------------------
        // held separately so either order works
        if (i_s_axi_awvalid & st_ff.aw_ready & ~do_write) begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid & st_ff.w_ready & ~do_write) begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_low = i_s_axi_wstrb[0];
            nxt_st.w_data = i_s_axi_wdata;
        end
        if (st_ff.bvalid & i_s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            case (wr_addr)
                ADDR_PORT1_CFG: if (wr_low) nxt_st.base1 = wr_data[CFG_BASE_BIT];
                ADDR_PORT2_CFG: if (wr_low) nxt_st.base2 = wr_data[CFG_BASE_BIT];
                ADDR_TOT_CFG: begin
                    if (wr_low) begin
                        nxt_st.tot_clr_on_read = wr_data[TOT_MODE_BIT];
                        nxt_st.tot_falling = wr_data[TOT_EDGE_BIT];
                    end
                end
                ADDR_PORT1_OUT, ADDR_PORT2_OUT, ADDR_TOT_CLEAR: nxt_st.bresp = RESP_OKAY;
                ADDR_PORT1_IN, ADDR_PORT2_IN, ADDR_TOT_COUNT, ADDR_CHAN_ID:
                    nxt_st.bresp = RESP_OKAY;
                default: nxt_st.bresp = RESP_SLVERR;
            endcase
        end

        // ------------------------------------------------------------
        // axi read channel
        // ------------------------------------------------------------
        if (st_ff.rvalid & i_s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (do_read) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_value;
            nxt_st.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
        end

        // ------------------------------------------------------------
        // totalizer
        // ------------------------------------------------------------
        // free running from reset, no start command needed
        nxt_st.pulse_prev = i_pulse;
        if (edge_seen) begin
            nxt_st.count = count_at_top ? COUNT_ZERO : st_ff.count + COUNT_ONE;
        end
        // a pulse in the clearing cycle is kept, so the count restarts at one
        if ((do_read & rd_clear) | wr_tot_clr) begin
            nxt_st.count = edge_seen ? COUNT_ONE : COUNT_ZERO;
        end

        // ------------------------------------------------------------
        // pin drivers
        // ------------------------------------------------------------
        // one more stage so pins and enables leave from flip-flops
        nxt_st.p1_out = port1_bus.pattern;
        nxt_st.p2_out = port2_bus.pattern;
        nxt_st.p1_oe = {PORT_W{port1_bus.dir_out}};
        nxt_st.p2_oe = {PORT_W{port2_bus.dir_out}};

        // ------------------------------------------------------------
        // handshake readies
        // ------------------------------------------------------------
        // registered inverses of the hold flags and of rvalid, so no gate sits on a ready
        nxt_st.aw_ready = ~nxt_st.aw_hold;
        nxt_st.w_ready = ~nxt_st.w_hold;
        nxt_st.ar_ready = ~nxt_st.rvalid;
    end

    // ----------------------------------------------------------------
    // pulse edges
    // ----------------------------------------------------------------
    // previous sample resets low like the idle line, so no false count
    assign pulse_rise = ~st_ff.pulse_prev & i_pulse;
    assign pulse_fall = st_ff.pulse_prev & ~i_pulse;
    assign edge_seen = st_ff.tot_falling ? pulse_fall : pulse_rise;
    // all ones is the last value before the count rolls over to zero
    assign count_at_top = &st_ff.count;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // readies come straight from their own flops
    assign o_s_axi_awready = st_ff.aw_ready;
    assign o_s_axi_wready = st_ff.w_ready;
    assign o_s_axi_bvalid = st_ff.bvalid;
    assign o_s_axi_bresp = st_ff.bresp;
    assign o_s_axi_arready = st_ff.ar_ready;
    assign o_s_axi_rvalid = st_ff.rvalid;
    assign o_s_axi_rdata = st_ff.rdata;
    assign o_s_axi_rresp = st_ff.rresp;
    assign o_port1_pins = st_ff.p1_out;
    assign o_port1_oe = st_ff.p1_oe;
    assign o_port2_pins = st_ff.p2_out;
    assign o_port2_oe = st_ff.p2_oe;
endmodule : mdiot_top
`default_nettype wire

// >>> mdiot_top_asserts.sv
// checker of the digital io and totalizer top
// assumes it is bound to mdiot_top and sees only its ports
`default_nettype none
module mdiot_top_asserts
    import mdiot_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [7:0] i_port1_pins,
    input wire logic [7:0] o_port1_pins,
    input wire logic [7:0] o_port1_oe,
    input wire logic [7:0] o_port2_oe,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_bvalid,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [1:0] o_s_axi_rresp,
    input wire logic o_s_axi_rvalid
);
    // ------------------------------------------------------------
    // port and bus properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    chk_oe_whole_port: assert property (o_port1_oe == 8'h00 || o_port1_oe == 8'hff)
        else $error("port 1 drive enable split");
    // a pattern may only move in the cycles right after a write answer
    chk_pattern_held: assert property (
        !o_s_axi_bvalid && !$past(o_s_axi_bvalid) && !$past(o_s_axi_bvalid, 2)
        |-> $stable(o_port1_pins) && $stable(o_port2_oe))
        else $error("port output moved without a write");
    chk_write_answer: assert property (
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |=> o_s_axi_bvalid)
        else $error("write not answered");
    chk_read_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read accepted while answer pending");
    chk_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read not answered");
    chk_chan_ids: assert property (
        i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == ADDR_CHAN_ID
        |=> o_s_axi_rdata == 32'h0003_0201)
        else $error("channel numbers wrong");
    chk_live_read: assert property (
        i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == ADDR_PORT1_IN
        |=> o_s_axi_rdata[7:0] == $past(i_port1_pins))
        else $error("port read not live");
    chk_unmapped_err: assert property (
        i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == 8'h3c
        |=> o_s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule : mdiot_top_asserts
bind mdiot_top mdiot_top_asserts u_chk (
    .i_clock, .i_rst_b, .i_port1_pins, .o_port1_pins, .o_port1_oe, .o_port2_oe,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid,
    .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
    .o_s_axi_rvalid
);
`default_nettype wire

// >>> tb.sv
// self-checking bench of the digital io and totalizer top
// assumes the far-side model drives the pins and the pulse line
`default_nettype none
module tb
    import mdiot_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic i_clock = 1'b0, i_rst_b = 1'b0, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
    logic i_s_axi_bready = 1'b0, i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0000_0000;
    logic [3:0] i_s_axi_wstrb = 4'hf;
    wire logic [7:0] i_port1_pins, i_port2_pins, o_port1_pins, o_port1_oe, o_port2_pins;
    wire logic [7:0] o_port2_oe;
    wire logic i_pulse, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
    wire logic o_s_axi_rvalid;
    wire logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    wire logic [31:0] o_s_axi_rdata;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    mdiot_top uut (
        .i_clock, .i_rst_b, .i_port1_pins, .i_port2_pins, .o_port1_pins, .o_port1_oe,
        .o_port2_pins, .o_port2_oe, .i_pulse, .i_s_axi_awaddr, .i_s_axi_awvalid,
        .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
        .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
        .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready
    );
    mdiot_pins_model far (
        .i_clock, .i_out1(o_port1_pins), .i_oe1(o_port1_oe), .i_out2(o_port2_pins),
        .i_oe2(o_port2_oe), .o_pins1(i_port1_pins), .o_pins2(i_port2_pins), .o_pulse(i_pulse)
    );
    initial begin
        forever #50 i_clock = ~i_clock;
    end
    // the run needs about 1000 cycles; far more means a hang
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // tasks and scenarios
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic settle();
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        logic [1:0] r;
        hb = 1'b0;
        @(posedge i_clock);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        while (!hb) begin
            @(negedge i_clock);
            ha = i_s_axi_awvalid && o_s_axi_awready;
            hw = i_s_axi_wvalid && o_s_axi_wready;
            hb = o_s_axi_bvalid;
            r = o_s_axi_bresp;
            @(posedge i_clock);
            if (ha) i_s_axi_awvalid <= 1'b0;
            if (hw) i_s_axi_wvalid <= 1'b0;
            if (hb) i_s_axi_bready <= 1'b0;
        end
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hr, hd;
        hd = 1'b0;
        @(posedge i_clock);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        while (!hd) begin
            @(negedge i_clock);
            hr = i_s_axi_arvalid && o_s_axi_arready;
            hd = o_s_axi_rvalid;
            d = o_s_axi_rdata;
            r = o_s_axi_rresp;
            @(posedge i_clock);
            if (hr) i_s_axi_arvalid <= 1'b0;
            if (hd) i_s_axi_rready <= 1'b0;
        end
    endtask : rd
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : rdc
    task automatic t_map();
        logic [31:0] d;
        logic [1:0] r;
        rdc("chan ids", ADDR_CHAN_ID, {8'h00, CHAN_TOT, CHAN_PORT2, CHAN_PORT1});
        rdc("port1 cfg", ADDR_PORT1_CFG, DATA_ZERO);
        rd(8'h3c, d, r);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(8'h3c, DATA_ZERO, RESP_SLVERR);
    endtask : t_map
    task automatic t_in();
        far.set_pins(8'ha5, 8'h3c);
        wr(ADDR_PORT1_IN, 32'h0000_00ff, RESP_OKAY);
        rdc("port1 live", ADDR_PORT1_IN, 32'h0000_00a5);
        rdc("port2 live", ADDR_PORT2_IN, 32'h0000_003c);
    endtask : t_in
    task automatic t_out();
        wr(ADDR_PORT1_OUT, 32'h0000_005a, RESP_OKAY);
        settle();
        chk("port1 oe", 32'h0000_00ff, {24'h0, o_port1_oe});
        chk("port2 oe", DATA_ZERO, {24'h0, o_port2_oe});
        rdc("port1 cfg", ADDR_PORT1_CFG, 32'h0000_0001);
        rdc("port1 live", ADDR_PORT1_IN, 32'h0000_005a);
        wr(ADDR_PORT1_CFG, 32'h0000_0003, RESP_OKAY);
        wr(ADDR_PORT2_OUT, 32'h0000_00c3, RESP_OKAY);
        settle();
        chk("port1 pins", 32'h0000_005a, {24'h0, o_port1_pins});
        chk("port2 pins", 32'h0000_00c3, {24'h0, o_port2_pins});
        rdc("port1 cfg", ADDR_PORT1_CFG, 32'h0000_0003);
        rdc("port2 cfg", ADDR_PORT2_CFG, 32'h0000_0001);
        rdc("port2 pattern", ADDR_PORT2_OUT, 32'h0000_00c3);
        i_s_axi_wstrb <= 4'h0;
        wr(ADDR_PORT2_OUT, 32'h0000_00ff, RESP_OKAY);
        i_s_axi_wstrb <= 4'hf;
        rdc("port2 no strobe", ADDR_PORT2_OUT, 32'h0000_00c3);
    endtask : t_out
    task automatic t_count();
        rdc("count idle", ADDR_TOT_COUNT, DATA_ZERO);
        far.toggle(10);
        settle();
        rdc("count run", ADDR_TOT_COUNT, 32'h0000_0005);
        rdc("count kept", ADDR_TOT_COUNT, 32'h0000_0005);
        wr(ADDR_TOT_CLEAR, 32'h0000_0001, RESP_OKAY);
        rdc("count clear", ADDR_TOT_COUNT, DATA_ZERO);
    endtask : t_count
    task automatic t_modes();
        wr(ADDR_TOT_CFG, 32'h0000_0001, RESP_OKAY);
        far.toggle(6);
        settle();
        rdc("count read", ADDR_TOT_COUNT, 32'h0000_0003);
        rdc("count reset", ADDR_TOT_COUNT, DATA_ZERO);
        wr(ADDR_TOT_CFG, 32'h0000_0002, RESP_OKAY);
        rdc("tot cfg", ADDR_TOT_CFG, 32'h0000_0002);
        far.toggle(1);
        settle();
        rdc("count rise", ADDR_TOT_COUNT, DATA_ZERO);
        far.toggle(1);
        settle();
        rdc("count fall", ADDR_TOT_COUNT, 32'h0000_0001);
    endtask : t_modes
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst_b <= 1'b1;
        t_map();
        t_in();
        t_out();
        t_count();
        t_modes();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
